// ===== rtl/branch_bit_instr_exec_regs.vh
// Register offsets, opcodes, field positions and reset values of the execution block
`ifndef BRANCH_BIT_INSTR_EXEC_REGS_VH
`define BRANCH_BIT_INSTR_EXEC_REGS_VH

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define OFS_INSTR 8'h00
`define OFS_PC 8'h04
`define OFS_STATUS 8'h08
`define OFS_CYCLES 8'h0C
`define OFS_GPR_SEL 8'h10
`define OFS_GPR_DATA 8'h14
`define OFS_IO_SEL 8'h18
`define OFS_IO_DATA 8'h1C
`define OFS_MEM_SEL 8'h20
`define OFS_MEM_DATA 8'h24

// ----------------------------------------------------------------
// Reset values and the all-lanes byte enable
// ----------------------------------------------------------------
`define PC_RST 16'h0000
`define STATUS_RST 8'h00
`define CYCLES_RST 32'h00000000
`define BYTES_ALL 4'hF

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define F_OP 29:25
`define F_RD 24:20
`define F_BIT 18:16
`define F_PORT 13:8
`define F_RR 12:8
`define F_K 7:0

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define FL_C 0
`define FL_Z 1
`define FL_N 2
`define FL_V 3
`define FL_S 4
`define FL_H 5
`define FL_T 6
`define FL_I 7

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_BRANCH_SET 5'h00
`define OP_BRANCH_CLEAR 5'h01
`define OP_INDIRECT_LOAD 5'h02
`define OP_INDIRECT_STORE 5'h03
`define OP_REGISTER_MOVE 5'h04
`define OP_IMMEDIATE_LOAD 5'h05
`define OP_PORT_IN 5'h06
`define OP_PORT_OUT 5'h07
`define OP_IO_BIT_SET 5'h08
`define OP_IO_BIT_CLEAR 5'h09
`define OP_LOGICAL_LEFT_SHIFT 5'h0A
`define OP_LOGICAL_RIGHT_SHIFT 5'h0B
`define OP_ROTATE_LEFT_CARRY 5'h0C
`define OP_ROTATE_RIGHT_CARRY 5'h0D
`define OP_ARITH_RIGHT_SHIFT 5'h0E
`define OP_NIBBLE_SWAP 5'h0F
`define OP_BIT_TO_TRANSFER_FLAG 5'h10
`define OP_TRANSFER_FLAG_TO_BIT 5'h11
`define OP_CARRY_SET 5'h12
`define OP_CARRY_CLEAR 5'h13

// ----------------------------------------------------------------
// Instruction cycle counts
// ----------------------------------------------------------------
`define CYC_ONE 32'h00000001
`define CYC_TWO 32'h00000002

`endif

// ===== rtl/branch_bit_instr_exec.v
// Instruction execution block for branches, moves, bit I/O, shifts and bit transfer
// ----------------------------------------------------------------
// Behaviour
// [RQ1] Status-bit branch: taken jumps PC+k+1, 1/2 cycles
// [RQ2] Equal on zero one, not-equal on zero
// [RQ3] Carry one or lower; carry zero or higher
// [RQ4] Negative/positive branches on N, flags untouched
// [RQ5] Signed branches test N xor V
// [RQ6] Half-carry branches both polarities, 1/2 cycles
// [RQ7] Transfer-flag branches both polarities
// [RQ8] Overflow branches both polarities
// [RQ9] Interrupt-enable branches both polarities
// [RQ10] I/O bit set/clear, flags kept, 2 cycles
// [RQ11] Left shift, zero in, Z C N V
// [RQ12] Right shift, zero into bit 7
// [RQ13] Rotate left through carry, one cycle
// [RQ14] Rotate right through carry, one cycle
// [RQ15] Arithmetic right shift keeps bit 7
// [RQ16] Nibble swap, no flags, one cycle
// [RQ17] Register bit copied into transfer flag
// [RQ18] Transfer flag copied into register bit
// [RQ19] Pointer load/store 2 cycles, moves 1, no flags
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "branch_bit_instr_exec_regs.vh"

module branch_bit_instr_exec #(
	parameter PC_W = 16,
	parameter MEM_AW = 6
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [7:0] avm_address_i,
	input wire avm_read_i,
	input wire avm_write_i,
	input wire [3:0] avm_byteenable_i,
	input wire [31:0] avm_writedata_i,
	output wire [31:0] avm_readdata_o,
	output wire avm_waitrequest_o
);

	// ----------------------------------------------------------------
	// State and storage
	// ----------------------------------------------------------------
	localparam S_IDLE = 2'h0;
	localparam S_EXEC2 = 2'h1;
	localparam S_ACK = 2'h2;

	reg [1:0] state_reg;
	reg [PC_W-1:0] pc_reg;
	reg [7:0] status_reg;
	reg [31:0] instr_reg;
	reg [31:0] cycles_reg;
	reg [31:0] rdata_reg;
	reg wait_reg;
	reg [4:0] gpr_sel_reg;
	reg [5:0] io_sel_reg;
	reg [MEM_AW-1:0] mem_sel_reg;

	reg [7:0] gpr [0:31];
	reg [7:0] io_space [0:63];
	reg [7:0] data_mem [0:(1<<MEM_AW)-1];

	assign avm_readdata_o = rdata_reg;
	assign avm_waitrequest_o = wait_reg;

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	wire idle = (state_reg == S_IDLE);
	wire rd_acc = idle && avm_read_i;
	wire wr_req = idle && avm_write_i && !avm_read_i;
	// Partial-lane writes are acknowledged but ignored
	wire wr_acc = wr_req && (avm_byteenable_i == `BYTES_ALL);
	wire exe1 = wr_acc && (avm_address_i == `OFS_INSTR);
	wire exe2 = (state_reg == S_EXEC2);

	// Second cycle works from the latched word, first from the bus
	wire [31:0] ins = exe2 ? instr_reg : avm_writedata_i;
	wire [4:0] op = ins[`F_OP];
	wire [4:0] rd = ins[`F_RD];
	wire [4:0] rr = ins[`F_RR];
	wire [2:0] bsel = ins[`F_BIT];
	wire [5:0] port = ins[`F_PORT];
	wire [7:0] kval = ins[`F_K];

	wire [7:0] rd_val = gpr[rd];
	wire [7:0] rr_val = gpr[rr];
	wire [7:0] io_val = io_space[port];
	wire [7:0] bmask = 8'h01 << bsel;
	wire [MEM_AW-1:0] zaddr = gpr[30][MEM_AW-1:0];

	// ----------------------------------------------------------------
	// Branch condition and target
	// ----------------------------------------------------------------
	// Index 4 is evaluated as N xor V so it never depends on a stale S bit
	wire signed_lt = status_reg[`FL_N] ^ status_reg[`FL_V]; // RQ5
	reg flag_sel;

	// One index per flag; the clear-branch opcode inverts the pick
	always @* begin
		case (bsel) // RQ1
			3'h0: flag_sel = status_reg[`FL_C]; // RQ3
			3'h1: flag_sel = status_reg[`FL_Z]; // RQ2
			3'h2: flag_sel = status_reg[`FL_N]; // RQ4
			3'h3: flag_sel = status_reg[`FL_V]; // RQ8
			3'h4: flag_sel = signed_lt; // RQ5
			3'h5: flag_sel = status_reg[`FL_H]; // RQ6
			3'h6: flag_sel = status_reg[`FL_T]; // RQ7
			3'h7: flag_sel = status_reg[`FL_I]; // RQ9
			default: flag_sel = status_reg[`FL_C];
		endcase
	end

	wire is_branch = (op == `OP_BRANCH_SET) || (op == `OP_BRANCH_CLEAR);
	wire br_taken = is_branch && ((op == `OP_BRANCH_SET) ? flag_sel : !flag_sel); // RQ2
	wire [PC_W-1:0] k_ext = {{(PC_W-8){kval[7]}}, kval};
	wire [PC_W-1:0] pc_seq = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
	wire [PC_W-1:0] pc_target = pc_seq + k_ext; // RQ1

	wire two_cycle = br_taken || (op == `OP_INDIRECT_LOAD) || (op == `OP_INDIRECT_STORE) ||
		(op == `OP_IO_BIT_SET) || (op == `OP_IO_BIT_CLEAR); // RQ1 RQ10 RQ19

	// ----------------------------------------------------------------
	// Execution datapath
	// ----------------------------------------------------------------
	reg [7:0] sh_res;
	reg sh_c;
	reg sh_upd;
	reg [7:0] status_next;
	reg gpr_we;
	reg [4:0] gpr_wa;
	reg [7:0] gpr_wd;
	reg io_we;
	reg [5:0] io_wa;
	reg [7:0] io_wd;
	reg mem_we;
	reg [MEM_AW-1:0] mem_wa;
	reg [7:0] mem_wd;

	always @* begin
		sh_res = rd_val;
		sh_c = status_reg[`FL_C];
		sh_upd = 1'b0;
		status_next = status_reg;
		gpr_we = 1'b0;
		gpr_wa = rd;
		gpr_wd = rd_val;
		io_we = 1'b0;
		io_wa = port;
		io_wd = io_val;
		mem_we = 1'b0;
		mem_wa = zaddr;
		mem_wd = rd_val;
		if (exe1) begin
			case (op)
				`OP_REGISTER_MOVE: begin
					gpr_we = 1'b1; // RQ19
					gpr_wd = rr_val;
				end
				`OP_IMMEDIATE_LOAD: begin
					gpr_we = 1'b1; // RQ19
					gpr_wd = kval;
				end
				`OP_PORT_IN: begin
					gpr_we = 1'b1; // RQ19
					gpr_wd = io_val;
				end
				`OP_PORT_OUT: begin
					io_we = 1'b1; // RQ19
					io_wd = rd_val;
				end
				`OP_LOGICAL_LEFT_SHIFT: begin
					sh_res = {rd_val[6:0], 1'b0}; // RQ11
					sh_c = rd_val[7];
					sh_upd = 1'b1;
				end
				`OP_LOGICAL_RIGHT_SHIFT: begin
					sh_res = {1'b0, rd_val[7:1]}; // RQ12
					sh_c = rd_val[0];
					sh_upd = 1'b1;
				end
				`OP_ROTATE_LEFT_CARRY: begin
					sh_res = {rd_val[6:0], status_reg[`FL_C]}; // RQ13
					sh_c = rd_val[7];
					sh_upd = 1'b1;
				end
				`OP_ROTATE_RIGHT_CARRY: begin
					sh_res = {status_reg[`FL_C], rd_val[7:1]}; // RQ14
					sh_c = rd_val[0];
					sh_upd = 1'b1;
				end
				`OP_ARITH_RIGHT_SHIFT: begin
					sh_res = {rd_val[7], rd_val[7:1]}; // RQ15
					sh_c = rd_val[0];
					sh_upd = 1'b1;
				end
				`OP_NIBBLE_SWAP: begin
					gpr_we = 1'b1; // RQ16
					gpr_wd = {rd_val[3:0], rd_val[7:4]};
				end
				`OP_BIT_TO_TRANSFER_FLAG: begin
					status_next[`FL_T] = |(rd_val & bmask); // RQ17
				end
				`OP_TRANSFER_FLAG_TO_BIT: begin
					gpr_we = 1'b1; // RQ18
					gpr_wd = status_reg[`FL_T] ? (rd_val | bmask) : (rd_val & ~bmask);
				end
				`OP_CARRY_SET: begin
					status_next[`FL_C] = 1'b1;
				end
				`OP_CARRY_CLEAR: begin
					status_next[`FL_C] = 1'b0;
				end
				default: begin
					status_next = status_reg; // RQ4
				end
			endcase
			if (sh_upd) begin
				gpr_we = 1'b1;
				gpr_wd = sh_res;
				status_next[`FL_C] = sh_c; // RQ11 RQ12 RQ13 RQ14 RQ15
				status_next[`FL_Z] = (sh_res == 8'h00);
				status_next[`FL_N] = sh_res[7];
				status_next[`FL_V] = sh_res[7] ^ sh_c;
			end
		end else if (exe2) begin
			case (op)
				`OP_INDIRECT_LOAD: begin
					gpr_we = 1'b1; // RQ19
					gpr_wd = data_mem[zaddr];
				end
				`OP_INDIRECT_STORE: begin
					mem_we = 1'b1; // RQ19
				end
				`OP_IO_BIT_SET: begin
					io_we = 1'b1; // RQ10
					io_wd = io_val | bmask;
				end
				`OP_IO_BIT_CLEAR: begin
					io_we = 1'b1; // RQ10
					io_wd = io_val & ~bmask;
				end
				default: begin
					gpr_we = 1'b0;
				end
			endcase
		end else if (wr_acc) begin
			case (avm_address_i)
				`OFS_GPR_DATA: begin
					gpr_we = 1'b1;
					gpr_wa = gpr_sel_reg;
					gpr_wd = avm_writedata_i[7:0];
				end
				`OFS_IO_DATA: begin
					io_we = 1'b1;
					io_wa = io_sel_reg;
					io_wd = avm_writedata_i[7:0];
				end
				`OFS_MEM_DATA: begin
					mem_we = 1'b1;
					mem_wa = mem_sel_reg;
					mem_wd = avm_writedata_i[7:0];
				end
				default: begin
					mem_we = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Storage arrays
	// ----------------------------------------------------------------
	// Left without reset: contents are data, not control state
	always @(posedge ref_clk_i) begin
		if (gpr_we) begin
			gpr[gpr_wa] <= gpr_wd;
		end
		if (io_we) begin
			io_space[io_wa] <= io_wd;
		end
		if (mem_we) begin
			data_mem[mem_wa] <= mem_wd;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h00000000;
		case (avm_address_i)
			`OFS_INSTR: rd_mux = instr_reg;
			`OFS_PC: rd_mux[PC_W-1:0] = pc_reg;
			`OFS_STATUS: rd_mux[7:0] = status_reg;
			`OFS_CYCLES: rd_mux = cycles_reg;
			`OFS_GPR_SEL: rd_mux[4:0] = gpr_sel_reg;
			`OFS_GPR_DATA: rd_mux[7:0] = gpr[gpr_sel_reg];
			`OFS_IO_SEL: rd_mux[5:0] = io_sel_reg;
			`OFS_IO_DATA: rd_mux[7:0] = io_space[io_sel_reg];
			`OFS_MEM_SEL: rd_mux[MEM_AW-1:0] = mem_sel_reg;
			`OFS_MEM_DATA: rd_mux[7:0] = data_mem[mem_sel_reg];
			default: rd_mux = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// Control and bus handshake
	// ----------------------------------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= S_IDLE;
			pc_reg <= `PC_RST;
			status_reg <= `STATUS_RST;
			instr_reg <= 32'h00000000;
			cycles_reg <= `CYCLES_RST;
			rdata_reg <= 32'h00000000;
			wait_reg <= 1'b1;
			gpr_sel_reg <= 5'h00;
			io_sel_reg <= 6'h00;
			mem_sel_reg <= {MEM_AW{1'b0}};
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (rd_acc) begin
						rdata_reg <= rd_mux;
						wait_reg <= 1'b0;
						state_reg <= S_ACK;
					end else if (wr_req) begin
						wait_reg <= 1'b0;
						state_reg <= S_ACK;
						if (exe1) begin
							instr_reg <= avm_writedata_i;
							status_reg <= status_next;
							pc_reg <= br_taken ? pc_target : pc_seq; // RQ1
							if (two_cycle) begin
								// Answer held back one cycle for the second phase
								cycles_reg <= cycles_reg + `CYC_TWO; // RQ1 RQ10
								wait_reg <= 1'b1;
								state_reg <= S_EXEC2;
							end else begin
								cycles_reg <= cycles_reg + `CYC_ONE; // RQ1
							end
						end else if (wr_acc) begin
							case (avm_address_i)
								`OFS_PC: pc_reg <= avm_writedata_i[PC_W-1:0];
								`OFS_STATUS: status_reg <= avm_writedata_i[7:0];
								`OFS_CYCLES: cycles_reg <= `CYCLES_RST;
								`OFS_GPR_SEL: gpr_sel_reg <= avm_writedata_i[4:0];
								`OFS_IO_SEL: io_sel_reg <= avm_writedata_i[5:0];
								`OFS_MEM_SEL: mem_sel_reg <= avm_writedata_i[MEM_AW-1:0];
								default: instr_reg <= instr_reg;
							endcase
						end
					end
				end
				S_EXEC2: begin
					wait_reg <= 1'b0;
					state_reg <= S_ACK;
				end
				S_ACK: begin
					wait_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				default: begin
					wait_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

endmodule // branch_bit_instr_exec

// ===== dv/branch_bit_instr_exec_sva.sv
// Bus timing checker bound to the execution block
`timescale 1ns/1ps
`include "branch_bit_instr_exec_regs.vh"
module branch_bit_instr_exec_sva #(
	parameter PC_W = 16,
	parameter MEM_AW = 6
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire [7:0] avm_address_i,
	input wire avm_read_i,
	input wire avm_write_i,
	input wire [3:0] avm_byteenable_i,
	input wire [31:0] avm_writedata_i,
	input wire [31:0] avm_readdata_o,
	input wire avm_waitrequest_o
);
	// ----------------------------------------------------------------
	// Instruction answer times
	// ----------------------------------------------------------------
	wire iw = avm_write_i && avm_address_i == `OFS_INSTR && avm_byteenable_i == `BYTES_ALL;
	wire [4:0] op = avm_writedata_i[`F_OP];
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_wait_pulse: assert property ($fell(avm_waitrequest_o) |=> avm_waitrequest_o)
		else $error("waitrequest low too long");
	chk_idle_high: assert property (!avm_read_i && !avm_write_i |=> avm_waitrequest_o)
		else $error("answer without request");
	chk_shift_one: assert property (
		$rose(iw) && op >= `OP_LOGICAL_LEFT_SHIFT && op <= `OP_ARITH_RIGHT_SHIFT
		|=> !avm_waitrequest_o) else $error("shift not one cycle");
	chk_swap_one: assert property (
		$rose(iw) && op == `OP_NIBBLE_SWAP |-> ##1 !avm_waitrequest_o)
		else $error("swap not one cycle");
	chk_bit_flag_one: assert property (
		$rose(iw) && op inside {`OP_BIT_TO_TRANSFER_FLAG, `OP_TRANSFER_FLAG_TO_BIT}
		|=> $fell(avm_waitrequest_o)) else $error("bit transfer not one cycle");
	chk_move_one: assert property (
		$rose(iw) && op >= `OP_REGISTER_MOVE && op <= `OP_PORT_OUT
		|=> !avm_waitrequest_o) else $error("move not one cycle");
	chk_ptr_two: assert property (
		$rose(iw) && op inside {`OP_INDIRECT_LOAD, `OP_INDIRECT_STORE}
		|=> avm_waitrequest_o ##1 !avm_waitrequest_o) else $error("pointer op not two cycles");
	chk_io_bit_two: assert property (
		$rose(iw) && op inside {`OP_IO_BIT_SET, `OP_IO_BIT_CLEAR}
		|=> avm_waitrequest_o ##1 $fell(avm_waitrequest_o)) else $error("io bit not two cycles");
endmodule // branch_bit_instr_exec_sva
bind branch_bit_instr_exec branch_bit_instr_exec_sva #(.PC_W(PC_W), .MEM_AW(MEM_AW)) u_sva (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avm_address_i(avm_address_i),
	.avm_read_i(avm_read_i), .avm_write_i(avm_write_i), .avm_byteenable_i(avm_byteenable_i),
	.avm_writedata_i(avm_writedata_i), .avm_readdata_o(avm_readdata_o),
	.avm_waitrequest_o(avm_waitrequest_o));

// ===== dv/avm_master_model.sv
// Avalon-MM master standing in for software on the register bus
`timescale 1ns/1ps
module avm_master_model (
	input wire clk_i,
	input wire waitrequest_i,
	input wire [31:0] readdata_i,
	output logic [7:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [3:0] byteenable_o,
	output logic [31:0] writedata_o
);
	initial begin
		{address_o, read_o, write_o, byteenable_o, writedata_o} = '0;
	end
	// Held until waitrequest is sampled low; bounded so a dead slave cannot hang the run
	task automatic xfer(input logic rw, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q, output bit to);
		int n;
		@(posedge clk_i);
		address_o <= a;
		read_o <= !rw;
		write_o <= rw;
		byteenable_o <= be;
		writedata_o <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_i !== 1'b0 && n < 50);
		q = readdata_i;
		to = n >= 50;
		read_o <= 1'b0;
		write_o <= 1'b0;
		// Released lines show garbage, not the last value
		address_o <= ~a;
		writedata_o <= ~d;
	endtask
endmodule // avm_master_model

// ===== dv/branch_bit_instr_exec_tb_top.sv
// Self-checking testbench of the execution block
`timescale 1ns/1ps
`include "branch_bit_instr_exec_regs.vh"
module branch_bit_instr_exec_tb_top;
	logic ref_clk_i;
	logic rst_n_i = 1'b0;
	wire [7:0] addr;
	wire rd_en, wr_en, wait_o;
	wire [3:0] be;
	wire [31:0] wdata, rdata;
	logic [31:0] q, lfsr = 32'hBF5B37EC;
	logic [15:0] pc, npc, e;
	logic [7:0] s, v, k;
	logic [5:0] p;
	logic [4:0] op, r;
	logic [2:0] b;
	logic tk;
	int err_count = 0;
	int n_checks = 0;
	branch_bit_instr_exec uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avm_address_i(addr),
		.avm_read_i(rd_en), .avm_write_i(wr_en), .avm_byteenable_i(be),
		.avm_writedata_i(wdata), .avm_readdata_o(rdata), .avm_waitrequest_o(wait_o));
	avm_master_model m (.clk_i(ref_clk_i), .waitrequest_i(wait_o), .readdata_i(rdata),
		.address_o(addr), .read_o(rd_en), .write_o(wr_en), .byteenable_o(be),
		.writedata_o(wdata));
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// ----------------------------------------------------------------
	// Helpers and reference functions
	// ----------------------------------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] iw(input logic [4:0] o, d, input logic [2:0] bi,
		input logic [5:0] pt, input logic [7:0] kk);
		return {2'b0, o, d, 1'b0, bi, 2'b0, pt, kk};
	endfunction
	// Returns {status, result}; V of a shift is N xor the new carry
	function automatic logic [15:0] sh(input logic [4:0] o, input logic [7:0] x, st,
		input logic [2:0] bi);
		logic [7:0] y;
		logic c;
		c = st[0];
		y = x;
		case (o)
			5'h0A: {c, y} = {x, 1'b0};
			5'h0B: {y, c} = {1'b0, x};
			5'h0C: {c, y} = {x, st[0]};
			5'h0D: {y, c} = {st[0], x};
			5'h0E: {y, c} = {x[7], x};
			5'h0F: y = {x[3:0], x[7:4]};
			5'h10: st[6] = x[bi];
			default: y[bi] = st[6];
		endcase
		if (o < 5'h0F)
			st[3:0] = {y[7] ^ c, y[7], y == 8'h00, c};
		return {st, y};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bus(input logic rw, input logic [7:0] a, input logic [3:0] en,
		input logic [31:0] d, output logic [31:0] qq);
		bit to;
		m.xfer(rw, a, en, d, qq, to);
		if (to) begin
			err_count++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, `BYTES_ALL, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		bus(1'b0, a, `BYTES_ALL, 32'h0, x);
	endtask
	task automatic setg(input logic [4:0] g, input logic [7:0] d);
		wr(`OFS_GPR_SEL, {27'h0, g});
		wr(`OFS_GPR_DATA, {24'h0, d});
	endtask
	task automatic getg(input logic [4:0] g, output logic [31:0] x);
		wr(`OFS_GPR_SEL, {27'h0, g});
		rd(`OFS_GPR_DATA, x);
	endtask
	task automatic run(input logic [31:0] ins, input logic [31:0] cyc);
		logic [31:0] x;
		wr(`OFS_CYCLES, 32'h0);
		wr(`OFS_INSTR, ins);
		rd(`OFS_CYCLES, x);
		chk(x, cyc);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rd(8'h80, q);
		chk(q, 32'h0);
		bus(1'b1, `OFS_PC, 4'h3, 32'h5, q);
		rd(`OFS_PC, q);
		chk(q, {16'h0, `PC_RST});
		for (int i = 0; i < 48; i++) begin
			lfsr = nxt(lfsr);
			s = lfsr[7:0];
			pc = (i < 16) ? 16'h0000 : lfsr[23:8];
			k = (i < 16) ? 8'h80 : lfsr[31:24];
			b = i[2:0];
			op = i[3] ? `OP_BRANCH_CLEAR : `OP_BRANCH_SET;
			tk = ((b == 3'h4) ? s[2] ^ s[3] : s[b]) == !i[3];
			npc = tk ? pc + {{8{k[7]}}, k} + 16'h0001 : pc + 16'h0001;
			wr(`OFS_STATUS, {24'h0, s});
			wr(`OFS_PC, {16'h0, pc});
			run(iw(op, 5'h00, b, 6'h00, k), tk ? `CYC_TWO : `CYC_ONE);
			rd(`OFS_PC, q);
			chk(q, {16'h0, npc});
			rd(`OFS_STATUS, q);
			chk(q, {24'h0, s});
		end
		for (int i = 0; i < 48; i++) begin
			lfsr = nxt(lfsr);
			v = (i < 8) ? 8'h80 : (i < 16) ? 8'h01 : lfsr[7:0];
			s = lfsr[15:8];
			b = lfsr[18:16];
			r = lfsr[23:19];
			op = 5'h0A + {2'b0, i[2:0]};
			setg(r, v);
			wr(`OFS_STATUS, {24'h0, s});
			run(iw(op, r, b, 6'h00, 8'h00), `CYC_ONE);
			e = sh(op, v, s, b);
			getg(r, q);
			chk(q, {24'h0, e[7:0]});
			rd(`OFS_STATUS, q);
			chk(q, {24'h0, e[15:8]});
		end
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			k = lfsr[7:0];
			s = lfsr[15:8];
			b = lfsr[18:16];
			p = lfsr[29:24];
			wr(`OFS_STATUS, {24'h0, s});
			run(iw(`OP_IMMEDIATE_LOAD, 5'h03, 3'h0, 6'h00, k), `CYC_ONE);
			run(iw(`OP_REGISTER_MOVE, 5'h04, 3'h0, 6'h03, 8'h00), `CYC_ONE);
			run(iw(`OP_PORT_OUT, 5'h04, 3'h0, p, 8'h00), `CYC_ONE);
			run(iw(`OP_IO_BIT_SET, 5'h00, b, p, 8'h00), `CYC_TWO);
			run(iw(`OP_IO_BIT_CLEAR, 5'h00, ~b, p, 8'h00), `CYC_TWO);
			v = k;
			v[b] = 1'b1;
			v[~b] = 1'b0;
			run(iw(`OP_PORT_IN, 5'h05, 3'h0, p, 8'h00), `CYC_ONE);
			getg(5'h05, q);
			chk(q, {24'h0, v});
			setg(5'h1E, {2'b0, p});
			run(iw(`OP_INDIRECT_STORE, 5'h05, 3'h0, 6'h05, 8'h00), `CYC_TWO);
			run(iw(`OP_INDIRECT_LOAD, 5'h06, 3'h0, 6'h06, 8'h00), `CYC_TWO);
			getg(5'h06, q);
			chk(q, {24'h0, v});
			rd(`OFS_STATUS, q);
			chk(q, {24'h0, s});
			// Carry ops seen through the carry branch, then an unused opcode
			run(iw(`OP_CARRY_SET, 5'h00, 3'h0, 6'h00, 8'h00), `CYC_ONE);
			run(iw(`OP_BRANCH_SET, 5'h00, 3'h0, 6'h00, k), `CYC_TWO);
			run(iw(`OP_CARRY_CLEAR, 5'h00, 3'h0, 6'h00, 8'h00), `CYC_ONE);
			run(iw(`OP_BRANCH_SET, 5'h00, 3'h0, 6'h00, k), `CYC_ONE);
			wr(`OFS_PC, {16'h0000, lfsr[31:16]});
			run(iw(5'h1F, 5'h00, 3'h0, 6'h00, 8'h00), `CYC_ONE);
			rd(`OFS_PC, q);
			chk(q, {16'h0000, lfsr[31:16] + 16'h0001});
			rd(`OFS_STATUS, q);
			chk(q, {24'h0, s & 8'hFE});
		end
		// Reset in mid-run brings back the reset values
		rst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rd(`OFS_PC, q);
		chk(q, {16'h0000, `PC_RST});
		rd(`OFS_STATUS, q);
		chk(q, {24'h0, `STATUS_RST});
		rd(`OFS_CYCLES, q);
		chk(q, `CYCLES_RST);
		conclude();
	end
endmodule // branch_bit_instr_exec_tb_top
